// ---- src/sldc_pkg.sv ----
package sldc_pkg;
  localparam int CLK_HZ       = 40_000_000;
  localparam int US_CYC       = CLK_HZ / 1_000_000;
  localparam int PWM_TO_US    = 300;
  localparam int PROG_TIME_MS = 200;
  localparam int PROG_CYC     = PROG_TIME_MS * (CLK_HZ / 1000);
  localparam int NREG         = 26;
  localparam int PWM_WIN      = 255;

  localparam logic [7:0] ADDR_BANK_SEL  = 8'h00;
  localparam logic [7:0] ADDR_CODE_BASE = 8'h01;
  localparam logic [7:0] ADDR_FADER     = 8'h13;
  localparam logic [7:0] ADDR_CTRL      = 8'h14;
  localparam logic [7:0] ADDR_ILIMIT    = 8'h15;
  localparam logic [7:0] ADDR_MASK      = 8'h16;
  localparam logic [7:0] ADDR_FAULT     = 8'h17;
  localparam logic [7:0] ADDR_HOLE      = 8'h18;
  localparam logic [7:0] ADDR_USER      = 8'h19;
  localparam logic [7:0] ADDR_NVM_CMD   = 8'h40;

  localparam int CTRL_PWM    = 0;
  localparam int CTRL_FADER  = 1;
  localparam int CTRL_TO_LSB = 2;
  localparam int NVM_RELOAD  = 0;
  localparam int NVM_STORE   = 1;
  localparam int NVM_UNLOCK  = 2;
  localparam int NVM_DONE    = 7;
  localparam logic [7:0] NVM_UNLOCK_CMD = 8'h04;
  localparam int F_OC        = 0;
  localparam int F_OT        = 1;
  localparam int F_UV        = 2;
  localparam int F_OPEN_LSB  = 3;
  localparam int F_SHORT_LSB = 5;
  localparam int M_OPEN      = 3;
  localparam int M_SHORT     = 4;

  // idle time before standby per timeout field, in microseconds
  localparam logic [3:0][13:0] IDLE_US = {14'd10000, 14'd5000, 14'd1000, 14'd500};

  // index 0 is offset 00h
  localparam logic [NREG-1:0][7:0] REG_DEFAULTS = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h00, 8'hff, 8'h00, 8'h4d, 8'h00,
    8'h4d, 8'h00, 8'h4d, 8'h00, 8'he7, 8'h00, 8'he7, 8'h00, 8'he7, 8'h01,
    8'h81, 8'h01, 8'h81, 8'h01, 8'h81, 8'h00};

  typedef enum logic [1:0] {SLDC_STARTUP, SLDC_STANDBY, SLDC_NORMAL} sldc_mode_e;
endpackage

// ---- src/sldc_nvm_if.sv ----
interface sldc_nvm_if;
  import sldc_pkg::*;
  logic                  load_req;
  logic                  store_req;
  logic [NREG-1:0][7:0]  image;
  logic                  busy;
  logic                  done_p;
  logic                  load_valid;
  logic [4:0]            load_idx;
  logic [7:0]            load_data;
  modport ctrl (output load_req, store_req, image,
                input busy, done_p, load_valid, load_idx, load_data);
  modport mem  (input load_req, store_req, image,
                output busy, done_p, load_valid, load_idx, load_data);
endinterface

// ---- src/sldc_nvm.sv ----
module sldc_nvm import sldc_pkg::*; #(
  parameter int PROG_CYCLES = PROG_CYC
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // store port
  sldc_nvm_if.mem  nvm
);
  if (PROG_CYCLES < 1) begin : g_chk
    $error("PROG_CYCLES must be at least 1");
  end

  typedef struct packed {
    logic [NREG-1:0][7:0] mem;
    logic                 loading;
    logic                 programming;
    logic [4:0]           idx;
    logic [31:0]          cnt;
    logic                 done;
  } sldc_nvm_s;

  sldc_nvm_s s, next_s;

  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    if (s.loading) begin
      if (s.idx == 5'(NREG - 1)) begin
        next_s.loading = 1'b0;
      end else begin
        next_s.idx = s.idx + 5'd1;
      end
    end else if (s.programming) begin
      if (s.cnt == 32'(PROG_CYCLES - 1)) begin
        next_s.programming = 1'b0;
        next_s.done        = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 32'd1;
      end
    end else if (nvm.load_req) begin
      next_s.loading = 1'b1;
      next_s.idx     = 5'd0;
    end else if (nvm.store_req) begin
      next_s.programming = 1'b1;
      next_s.cnt         = 32'd0;
      next_s.mem         = nvm.image;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s     <= '0;
      s.mem <= REG_DEFAULTS;
    end else begin
      s <= next_s;
    end
  end

  assign nvm.busy       = s.loading | s.programming;
  assign nvm.done_p     = s.done;
  assign nvm.load_valid = s.loading;
  assign nvm.load_idx   = s.idx;
  assign nvm.load_data  = s.mem[s.idx];
endmodule

// ---- src/sldc_top.sv ----
// Summary of operation
// - one colour driven at a time, waits drop
// - pending colours chosen red, green, blue
// - three banks of 10-bit codes, low/high
// - bank select low bits 00, 01, else bank two
// - host accesses only working registers
// - all but fault and command are storable
// - startup copies stored values to registers
// - 04h then 01h to 40h reloads
// - 04h then 02h to 40h stores
// - store ends, done flag set to one
// - two control bits pick brightness source
// - factor is duty or fader over 255
// - scaling keeps the channel current ratios
// - duty applies at rise if 300 us old
// - fault sets flag, unmasked drives pin low
// - fault read clears flags, releases pin
// - open: converter_output_voltage max, no current, no overcurrent
// - short: converter_output_voltage below 1.0V at end
// - overtemperature flags and forces standby
// - undervoltage flags, standby, reload on recovery
// - overcurrent only if limit active at end
// - all enables low for timeout gives standby
module sldc_top import sldc_pkg::*; #(
  parameter int PROG_CYCLES = PROG_CYC
) (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  // colour enables and brightness input
  input  wire logic [2:0] colour_en_i,
  input  wire logic       pwm_i,
  // analog status
  input  wire logic       overtemp_i,
  input  wire logic       undervolt_i,
  input  wire logic       converter_output_voltage_at_max_i,
  input  wire logic       driver_no_current_i,
  input  wire logic       converter_output_voltage_below_short_i,
  input  wire logic       pos_limit_i,
  // register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // driver control
  output logic      [2:0] drive_en_o,
  output logic      [9:0] drive_code_o,
  // open-drain fault pin
  output logic            fault_o,
  output logic            fault_oe_o
);
  localparam logic [1:0] ACT_NONE = 2'd3;

  if (PROG_CYCLES < 1) begin : g_chk
    $error("PROG_CYCLES must be at least 1");
  end

  typedef struct packed {
    sldc_mode_e           mode;
    logic [NREG-1:0][7:0] regs;
    logic [7:0]           fault;
    logic                 unlock;
    logic                 done;
    logic                 load_req;
    logic                 store_req;
    logic                 load_sent;
    logic                 uv_prev;
    logic [1:0]           act;
    logic [5:0]           tick_cnt;
    logic [7:0]           win;
    logic [7:0]           high;
    logic [7:0]           duty;
    logic [8:0]           age;
    logic [7:0]           brc_pwm;
    logic [13:0]          idle;
    logic [7:0]           rdata;
    logic [2:0]           drive_en;
    logic [9:0]           drive_code;
    logic                 fault_oe;
  } sldc_state_s;

  sldc_state_s s, next_s;
  sldc_nvm_if  nvm_bus ();
  logic [7:0]  fset;
  logic        fclr;

  sldc_nvm #(
    .PROG_CYCLES (PROG_CYCLES)
  ) u_nvm (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .nvm       (nvm_bus.mem)
  );

  function automatic logic [1:0] bank_of(input logic [7:0] sel);
    return sel[1] ? 2'd2 : {1'b0, sel[0]};
  endfunction

  function automatic logic [9:0] code_of(input logic [NREG-1:0][7:0] r,
                                         input logic [1:0] bank,
                                         input logic [1:0] ch);
    logic [4:0] lo;
    lo = 5'(ADDR_CODE_BASE) + 5'd6 * 5'(bank) + 5'd2 * 5'(ch);
    return {r[lo + 5'd1][1:0], r[lo]};
  endfunction

  function automatic logic [1:0] prio(input logic [2:0] en);
    if (en[0]) begin
      return 2'd0;
    end else if (en[1]) begin
      return 2'd1;
    end else if (en[2]) begin
      return 2'd2;
    end
    return ACT_NONE;
  endfunction

  // factor is brc/255; the same factor on every code keeps the ratios
  function automatic logic [9:0] scale(input logic [9:0] code, input logic [7:0] brightness_factor);
    logic [17:0] p;
    p = 18'(code) * 18'(brightness_factor);
    return 10'(p / 18'd255);
  endfunction

  always_comb begin
    logic       tick;
    logic [7:0] hnext;
    logic [7:0] brightness_factor;
    logic       start;
    logic       in_ch;
    logic [7:0] msk;
    hnext             = 8'h00;
    brightness_factor               = 8'hff;
    next_s            = s;
    next_s.load_req   = 1'b0;
    next_s.store_req  = 1'b0;
    fset              = 8'h00;
    fclr              = 1'b0;
    msk               = s.regs[ADDR_MASK];
    tick              = (s.tick_cnt == 6'(US_CYC - 1));
    next_s.tick_cnt   = tick ? 6'd0 : s.tick_cnt + 6'd1;
    next_s.uv_prev    = undervolt_i;

    // duty measured over a window of 255 microsecond samples
    if (tick) begin
      if (s.age < 9'(PWM_TO_US)) begin
        next_s.age = s.age + 9'd1;
      end
      if (s.win == 8'(PWM_WIN - 1)) begin
        hnext       = s.high + 8'(pwm_i);
        next_s.duty = hnext;
        next_s.win  = 8'd0;
        next_s.high = 8'd0;
        if (hnext != s.duty) begin
          next_s.age = 9'd0;
        end
      end else begin
        next_s.win  = s.win + 8'd1;
        next_s.high = s.high + 8'(pwm_i);
      end
    end

    // startup load and mode sequencing
    case (s.mode)
      SLDC_STARTUP: begin
        if (!s.load_sent) begin
          next_s.load_req  = 1'b1;
          next_s.load_sent = 1'b1;
        end else if (!s.load_req && !nvm_bus.busy) begin
          next_s.mode = SLDC_STANDBY;
        end
      end
      SLDC_STANDBY: begin
        next_s.act = ACT_NONE;
        if (!overtemp_i && !undervolt_i && colour_en_i != 3'b000) begin
          next_s.mode = SLDC_NORMAL;
          next_s.idle = 14'd0;
        end
      end
      SLDC_NORMAL: begin
        if (overtemp_i || undervolt_i) begin
          next_s.mode = SLDC_STANDBY;
          next_s.act  = ACT_NONE;
        end else begin
          if (s.act == ACT_NONE) begin
            next_s.act = prio(colour_en_i);
          end else if (!colour_en_i[s.act]) begin
            next_s.act = prio(colour_en_i);
            // end of colour period: sample converter status
            if (pos_limit_i) begin
              fset[F_OC] = 1'b1;
            end
            if (converter_output_voltage_at_max_i && driver_no_current_i && !pos_limit_i) begin
              fset[F_OPEN_LSB +: 2] = s.act + 2'd1;
            end
            if (converter_output_voltage_below_short_i) begin
              fset[F_SHORT_LSB +: 2] = s.act + 2'd1;
            end
          end
          if (colour_en_i != 3'b000) begin
            next_s.idle = 14'd0;
          end else if (tick) begin
            next_s.idle = s.idle + 14'd1;
            if (s.idle + 14'd1 >= IDLE_US[s.regs[ADDR_CTRL][CTRL_TO_LSB +: 2]]) begin
              next_s.mode = SLDC_STANDBY;
            end
          end
        end
      end
      default: next_s.mode = SLDC_STARTUP;
    endcase

    // new colour turns on: take the duty only if it has settled
    start = (next_s.act != ACT_NONE) && (next_s.act != s.act);
    if (start && s.age >= 9'(PWM_TO_US)) begin
      next_s.brc_pwm = s.duty;
    end

    if (overtemp_i) begin
      fset[F_OT] = 1'b1;
    end
    if (undervolt_i) begin
      fset[F_UV] = 1'b1;
    end
    if (s.uv_prev && !undervolt_i && !nvm_bus.busy) begin
      next_s.load_req = 1'b1;
    end

    // register access, always to working registers
    in_ch = reg_addr_i < 8'(NREG) && reg_addr_i != ADDR_FAULT && reg_addr_i != ADDR_HOLE;
    if (reg_wr_i) begin
      if (reg_addr_i == ADDR_NVM_CMD) begin
        if (reg_wdata_i == NVM_UNLOCK_CMD) begin
          next_s.unlock = 1'b1;
        end else begin
          next_s.unlock = 1'b0;
          if (s.unlock && !nvm_bus.busy && reg_wdata_i[NVM_RELOAD]) begin
            next_s.load_req = 1'b1;
          end else if (s.unlock && !nvm_bus.busy && reg_wdata_i[NVM_STORE]) begin
            next_s.store_req = 1'b1;
            next_s.done      = 1'b0;
          end
        end
      end else if (in_ch) begin
        next_s.regs[5'(reg_addr_i)] = reg_wdata_i;
      end
    end
    if (nvm_bus.load_valid && nvm_bus.load_idx != 5'(ADDR_FAULT)) begin
      next_s.regs[nvm_bus.load_idx] = nvm_bus.load_data;
    end
    if (nvm_bus.done_p) begin
      next_s.done = 1'b1;
    end

    next_s.rdata = 8'h00;
    if (reg_rd_i) begin
      if (reg_addr_i == ADDR_FAULT) begin
        next_s.rdata = s.fault;
        fclr         = 1'b1;
      end else if (reg_addr_i == ADDR_NVM_CMD) begin
        next_s.rdata[NVM_DONE]   = s.done;
        next_s.rdata[NVM_UNLOCK] = s.unlock;
      end else if (in_ch) begin
        next_s.rdata = s.regs[5'(reg_addr_i)];
      end
    end

    // set wins over the clearing read
    next_s.fault    = (fclr ? 8'h00 : s.fault) | fset;
    next_s.fault_oe = (s.fault_oe && !fclr)
                    | (fset[F_OC] && !msk[F_OC])
                    | (fset[F_OT] && !msk[F_OT])
                    | (fset[F_UV] && !msk[F_UV])
                    | (fset[F_OPEN_LSB +: 2] != 2'd0 && !msk[M_OPEN])
                    | (fset[F_SHORT_LSB +: 2] != 2'd0 && !msk[M_SHORT]);

    // brightness source and scaled drive code
    if (s.regs[ADDR_CTRL][CTRL_PWM]) begin
      brightness_factor = next_s.brc_pwm;
    end else if (s.regs[ADDR_CTRL][CTRL_FADER]) begin
      brightness_factor = s.regs[ADDR_FADER];
    end else begin
      brightness_factor = 8'hff;
    end
    next_s.drive_en   = 3'b000;
    next_s.drive_code = 10'd0;
    if (next_s.mode == SLDC_NORMAL && next_s.act != ACT_NONE) begin
      next_s.drive_en[next_s.act] = 1'b1;
      next_s.drive_code = scale(code_of(s.regs, bank_of(s.regs[ADDR_BANK_SEL]),
                                        next_s.act), brightness_factor);
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s         <= '0;
      s.mode    <= SLDC_STARTUP;
      s.regs    <= REG_DEFAULTS;
      s.act     <= ACT_NONE;
      s.duty    <= 8'hff;
      s.brc_pwm <= 8'hff;
    end else begin
      s <= next_s;
    end
  end

  // store image leaves out the fault flags, which are never kept
  always_comb begin
    nvm_bus.image             = s.regs;
    nvm_bus.image[ADDR_FAULT] = 8'h00;
  end
  assign nvm_bus.load_req  = s.load_req;
  assign nvm_bus.store_req = s.store_req;

  assign reg_rdata_o  = s.rdata;
  assign drive_en_o   = s.drive_en;
  assign drive_code_o = s.drive_code;
  assign fault_o      = 1'b0;
  assign fault_oe_o   = s.fault_oe;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  a_one_colour: assert property ($onehot0(drive_en_o))
    else $error("more than one colour driven");
  a_hold_active: assert property (
    (s.mode == SLDC_NORMAL && s.act != ACT_NONE && colour_en_i[s.act]
     && !overtemp_i && !undervolt_i) |=> s.act == $past(s.act))
    else $error("active colour dropped while enable high");
  a_red_first: assert property (
    (s.mode == SLDC_NORMAL && s.act != ACT_NONE && !colour_en_i[s.act]
     && colour_en_i[0] && !overtemp_i && !undervolt_i) |=> drive_en_o == 3'b001)
    else $error("red not chosen first");
  a_fault_clear: assert property (
    (reg_rd_i && reg_addr_i == ADDR_FAULT && fset == 8'h00)
    |=> s.fault == 8'h00 && !fault_oe_o)
    else $error("fault read did not clear");
  a_set_wins: assert property (
    (fset != 8'h00) |=> (s.fault & $past(fset)) == $past(fset))
    else $error("fault event lost");
  a_fault_pin: assert property (
    (fset[F_OT] && !s.regs[ADDR_MASK][F_OT]) |=> fault_oe_o)
    else $error("unmasked fault did not pull pin");
  a_ot_standby: assert property (
    overtemp_i |=> s.mode != SLDC_NORMAL && drive_en_o == 3'b000)
    else $error("overtemperature did not force standby");
  a_store_start: assert property (
    (s.unlock && reg_wr_i && reg_addr_i == ADDR_NVM_CMD && reg_wdata_i == 8'h02
     && !nvm_bus.busy) |=> s.store_req ##1 nvm_bus.busy)
    else $error("store did not start");
  a_store_done: assert property (
    nvm_bus.done_p |=> s.done)
    else $error("done flag not set");

  c_switch:  cover property (drive_en_o == 3'b010 ##1 drive_en_o == 3'b001);
  c_store:   cover property (nvm_bus.done_p);
  c_readclr: cover property (fclr && s.fault != 8'h00);
endmodule

// ---- verif/sldc_ctrl_model.sv ----
module sldc_ctrl_model (
  // clock
  input  wire logic       clk_i,
  // colour enables and brightness
  output logic      [2:0] colour_en_o,
  output logic            pwm_o,
  // analog status: {pos_limit, below_short, no_current, at_max}
  output logic            overtemp_o,
  output logic            undervolt_o,
  output logic      [3:0] end_st_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    colour_en_o = 3'h0;
    pwm_o       = 1'b1;
    overtemp_o  = 1'b0;
    undervolt_o = 1'b0;
    end_st_o    = 4'h0;
  end

  // every change lands just after a falling edge
  task automatic set_en(input logic [2:0] en);
    @(negedge clk_i);
    colour_en_o = en;
  endtask

  task automatic set_pwm(input logic lvl);
    @(negedge clk_i);
    pwm_o = lvl;
  endtask

  task automatic set_flt(input logic ot, input logic uv);
    @(negedge clk_i);
    overtemp_o  = ot;
    undervolt_o = uv;
  endtask

  // status shows the end of the colour period, held over the drop, then removed
  task automatic end_colour(input logic [2:0] en, input logic [3:0] st);
    @(negedge clk_i);
    end_st_o = st;
    @(negedge clk_i);
    colour_en_o = en;
    repeat (2) @(negedge clk_i);
    end_st_o = 4'h0;
  endtask
endmodule

// ---- verif/sldc_tb_top.sv ----
module sldc_tb_top;
  import sldc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk_sys_i;
  logic       resetn_i;
  logic [7:0] reg_addr_i;
  logic       reg_wr_i;
  logic       reg_rd_i;
  logic [7:0] reg_wdata_i;
  logic [7:0] reg_rdata_o;
  logic [2:0] drive_en_o;
  logic [9:0] drive_code_o;
  logic       fault_o;
  logic       fault_oe_o;
  logic [2:0] colour_en;
  logic       pwm;
  logic       ot;
  logic       uv;
  logic [3:0] st;
  logic [7:0] d;
  int         n_fail;
  int         total_checks;

  localparam logic [7:0][15:0] DFLT = {16'h0000, 16'h0181, 16'h0201, 16'h07e7,
                                       16'h0d4d, 16'h13ff, 16'h1511, 16'h1900};
  localparam logic [6:0][2:0] SEQ_EN = {3'h1, 3'h3, 3'h2, 3'h7, 3'h5, 3'h4, 3'h0};
  localparam logic [6:0][2:0] SEQ_DR = {3'h1, 3'h1, 3'h2, 3'h2, 3'h1, 3'h4, 3'h0};
  localparam logic [6:0][9:0] SEQ_CD = {10'h181, 10'h181, 10'h040, 10'h040,
                                       10'h181, 10'h181, 10'h000};

  sldc_ctrl_model ctl (
    .clk_i       (clk_sys_i),
    .colour_en_o (colour_en),
    .pwm_o       (pwm),
    .overtemp_o  (ot),
    .undervolt_o (uv),
    .end_st_o    (st)
  );

  sldc_top #(.PROG_CYCLES(20)) uut (
    .clk_sys_i           (clk_sys_i),
    .resetn_i            (resetn_i),
    .colour_en_i         (colour_en),
    .pwm_i               (pwm),
    .overtemp_i          (ot),
    .undervolt_i         (uv),
    .converter_output_voltage_at_max_i       (st[0]),
    .driver_no_current_i (st[1]),
    .converter_output_voltage_below_short_i  (st[2]),
    .pos_limit_i         (st[3]),
    .reg_addr_i          (reg_addr_i),
    .reg_wr_i            (reg_wr_i),
    .reg_rd_i            (reg_rd_i),
    .reg_wdata_i         (reg_wdata_i),
    .reg_rdata_o         (reg_rdata_o),
    .drive_en_o          (drive_en_o),
    .drive_code_o        (drive_code_o),
    .fault_o             (fault_o),
    .fault_oe_o          (fault_oe_o)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic results();
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys_i);
    reg_addr_i  = a;
    reg_wdata_i = v;
    reg_wr_i    = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_rd_i   = 1'b1;
    @(negedge clk_sys_i);
    reg_rd_i = 1'b0;
    v = reg_rdata_o;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk($sformatf("reg %h", a), {2'h0, v}, {2'h0, exp});
  endtask

  // drive state once the colour pick has settled
  task automatic drv(input logic [2:0] e, input logic [9:0] c);
    repeat (4) @(negedge clk_sys_i);
    chk("drive_en", {7'h0, drive_en_o}, {7'h0, e});
    chk("drive_code", drive_code_o, c);
  endtask

  task automatic pin(input logic oe);
    repeat (2) @(negedge clk_sys_i);
    chk("fault pin", {8'h0, fault_oe_o, fault_o}, {8'h0, oe, 1'b0});
  endtask

  initial begin
    #2ms;
    n_fail++;
    results();
  end

  initial begin
    resetn_i    = 1'b0;
    reg_addr_i  = 8'h00;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    reg_wdata_i = 8'h00;
    repeat (3) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    repeat (40) @(negedge clk_sys_i);
    for (int i = 0; i < 8; i++) rchk(DFLT[i][15:8], DFLT[i][7:0]);
    rchk(ADDR_HOLE, 8'h00);
    wr(8'h01, 8'h55);
    wr(ADDR_NVM_CMD, NVM_UNLOCK_CMD);
    wr(ADDR_NVM_CMD, 8'h02);
    d = 8'h00;
    for (int k = 0; k < 60 && d[7] !== 1'b1; k++) rd(ADDR_NVM_CMD, d);
    chk("store done", {9'h0, d[7]}, 10'h001);
    wr(8'h01, 8'h00);
    rchk(8'h01, 8'h00);
    wr(ADDR_NVM_CMD, NVM_UNLOCK_CMD);
    wr(ADDR_NVM_CMD, 8'h01);
    repeat (40) @(negedge clk_sys_i);
    rchk(8'h01, 8'h55);
    wr(8'h01, 8'h81);
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_BANK_SEL, 8'(b));
      ctl.set_en(3'h1);
      drv(3'h1, b == 0 ? 10'h181 : (b == 1 ? 10'h0e7 : 10'h04d));
      ctl.set_en(3'h0);
    end
    wr(ADDR_BANK_SEL, 8'h00);
    wr(8'h03, 8'h40);
    wr(8'h04, 8'h00);
    for (int i = 6; i >= 0; i--) begin
      ctl.set_en(SEQ_EN[i]);
      drv(SEQ_DR[i], SEQ_CD[i]);
    end
    wr(ADDR_FADER, 8'h80);
    wr(ADDR_CTRL, 8'h02);
    ctl.set_en(3'h1);
    drv(3'h1, 10'h0c1);
    ctl.set_en(3'h2);
    drv(3'h2, 10'h020);
    ctl.set_en(3'h0);
    wr(ADDR_CTRL, 8'h03);
    repeat (24000) @(negedge clk_sys_i);
    ctl.set_en(3'h1);
    drv(3'h1, 10'h181);
    ctl.set_pwm(1'b0);
    repeat (400) @(negedge clk_sys_i);
    ctl.set_en(3'h2);
    drv(3'h2, 10'h040);
    // duty change is seen at a window end, up to two windows late, then must age
    repeat (34000) @(negedge clk_sys_i);
    ctl.set_en(3'h4);
    drv(3'h4, 10'h000);
    ctl.set_en(3'h0);
    wr(ADDR_CTRL, 8'h00);
    ctl.set_en(3'h1);
    drv(3'h1, 10'h181);
    ctl.end_colour(3'h0, 4'h8);
    pin(1'b1);
    rchk(ADDR_FAULT, 8'h01);
    pin(1'b0);
    rchk(ADDR_FAULT, 8'h00);
    ctl.set_en(3'h1);
    drv(3'h1, 10'h181);
    ctl.end_colour(3'h1, 4'h8);
    ctl.end_colour(3'h0, 4'h0);
    rchk(ADDR_FAULT, 8'h00);
    wr(ADDR_MASK, 8'h08);
    ctl.set_en(3'h1);
    drv(3'h1, 10'h181);
    ctl.end_colour(3'h0, 4'h3);
    pin(1'b0);
    rchk(ADDR_FAULT, 8'h08);
    ctl.set_en(3'h2);
    drv(3'h2, 10'h040);
    ctl.end_colour(3'h0, 4'h4);
    pin(1'b1);
    rchk(ADDR_FAULT, 8'h40);
    ctl.set_en(3'h1);
    drv(3'h1, 10'h181);
    ctl.set_flt(1'b1, 1'b0);
    drv(3'h0, 10'h000);
    ctl.set_flt(1'b0, 1'b0);
    ctl.set_en(3'h0);
    rchk(ADDR_FAULT, 8'h02);
    wr(8'h01, 8'h12);
    ctl.set_flt(1'b0, 1'b1);
    repeat (3) @(negedge clk_sys_i);
    ctl.set_flt(1'b0, 1'b0);
    repeat (40) @(negedge clk_sys_i);
    rchk(ADDR_FAULT, 8'h04);
    rchk(8'h01, 8'h55);
    results();
  end
endmodule
